// File: core/dbfw_bus_cycle.sv
// One bus cycle on the flash pins: write or read, with timing
`timescale 1ns/1ps
`default_nettype none
module dbfw_bus_cycle
   import dbfw_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Cycle request
   input wire logic start,
   input wire logic is_write,
   input wire logic [1:0] lanes,
   input wire logic [16:0] addr,
   input wire logic [15:0] wdata,
   output logic done,
   output logic [15:0] rdata,
   // Flash pins
   output logic [16:0] flash_addr,
   output logic low_byte_select_n,
   output logic high_byte_select_n,
   output logic write_strobe_n,
   output logic output_enable_n,
   output logic [15:0] flash_dq_out,
   output logic flash_dq_oe_n,
   input wire logic [15:0] flash_dq_in
);
   typedef enum logic [1:0] {
      BC_IDLE = 2'b00,
      BC_SETUP = 2'b01,
      BC_ACTIVE = 2'b10,
      BC_HOLD = 2'b11
   } dbfw_bc_e;
   dbfw_bc_e state_reg;
   logic [7:0] cnt_reg;
   logic wr_reg;
   logic [15:0] sync1_reg;
   logic [15:0] sync2_reg;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sync1_reg <= 16'h0000;
         sync2_reg <= 16'h0000;
      end else begin
         sync1_reg <= flash_dq_in;
         sync2_reg <= sync1_reg;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= BC_IDLE;
         cnt_reg <= 8'h00;
         wr_reg <= 1'b0;
         done <= 1'b0;
         rdata <= 16'h0000;
         flash_addr <= 17'h00000;
         low_byte_select_n <= 1'b1;
         high_byte_select_n <= 1'b1;
         write_strobe_n <= 1'b1;
         output_enable_n <= 1'b1;
         flash_dq_out <= 16'h0000;
         flash_dq_oe_n <= 1'b1;
      end else begin
         done <= 1'b0;
         unique case (state_reg)
            BC_IDLE: begin
               if (start) begin
                  wr_reg <= is_write;
                  flash_addr <= addr;
                  flash_dq_out <= wdata;
                  // Only selected lanes take writes or drive data
                  low_byte_select_n <= ~lanes[0];
                  high_byte_select_n <= ~lanes[1];
                  flash_dq_oe_n <= ~is_write;
                  cnt_reg <= 8'(SETUP_CYC);
                  state_reg <= BC_SETUP;
               end
            end
            BC_SETUP: begin
               if (cnt_reg == 8'h00) begin
                  // Strobe asserted only inside the select window
                  write_strobe_n <= ~wr_reg;
                  output_enable_n <= wr_reg;
                  cnt_reg <= wr_reg ? 8'(PULSE_CYC) : 8'(ACCESS_CYC);
                  state_reg <= BC_ACTIVE;
               end else begin
                  cnt_reg <= cnt_reg - 8'h01;
               end
            end
            BC_ACTIVE: begin
               if (cnt_reg == 8'h00) begin
                  write_strobe_n <= 1'b1;
                  output_enable_n <= 1'b1;
                  rdata <= sync2_reg;
                  cnt_reg <= 8'(HOLD_CYC);
                  state_reg <= BC_HOLD;
               end else begin
                  cnt_reg <= cnt_reg - 8'h01;
               end
            end
            BC_HOLD: begin
               if (cnt_reg == 8'h00) begin
                  low_byte_select_n <= 1'b1;
                  high_byte_select_n <= 1'b1;
                  flash_dq_oe_n <= 1'b1;
                  done <= 1'b1;
                  state_reg <= BC_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 8'h01;
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// File: core/dbfw_host.sv
// Host sequencer for program, erase and read of the dual byte flash
`timescale 1ns/1ps
`default_nettype none
module dbfw_host
   import dbfw_pkg::*;
#(
   parameter int PROG_CYCLES = PROG_CYC,
   parameter int ERASE_CYCLES = ERASE_CYC,
   parameter int RECOV_CYCLES = RECOV_CYC
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // User request
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [1:0] req_op,
   input wire logic [1:0] req_lanes,
   input wire logic [16:0] req_addr,
   input wire logic [15:0] req_wdata,
   // User answer
   output logic resp_valid,
   output logic [15:0] resp_rdata,
   output logic resp_mismatch,
   // Flash pins
   output logic [16:0] flash_addr,
   output logic low_byte_select_n,
   output logic high_byte_select_n,
   output logic write_strobe_n,
   output logic output_enable_n,
   output logic [15:0] flash_dq_out,
   output logic flash_dq_oe_n,
   input wire logic [15:0] flash_dq_in
);
   typedef enum logic [2:0] {
      HS_IDLE = 3'b000,
      HS_CMD = 3'b001,
      HS_DATA = 3'b010,
      HS_WAIT = 3'b011,
      HS_VERIFY_CMD = 3'b100,
      HS_RECOVER = 3'b101,
      HS_READ = 3'b110,
      HS_DONE = 3'b111
   } dbfw_hs_e;

   dbfw_hs_e state_reg;
   logic [1:0] op_reg;
   logic [1:0] lanes_reg;
   logic [16:0] addr_reg;
   logic [15:0] wdata_reg;
   logic [CNT_W-1:0] wait_reg;
   logic issued_reg;
   logic bc_start;
   logic bc_write;
   logic [1:0] bc_lanes;
   logic [15:0] bc_wdata;
   logic bc_done;
   logic [15:0] bc_rdata;

   // Byte command duplicated per lane, 00H on an unselected lane
   function automatic logic [15:0] lane_cmd(input logic [7:0] cmd, input logic [1:0] lanes);
      lane_cmd = {lanes[1] ? cmd : CMD_NULL, lanes[0] ? cmd : CMD_NULL};
   endfunction

   // Byte mask of the lanes taking part in an operation
   function automatic logic [15:0] lane_mask(input logic [1:0] lanes);
      lane_mask = {{8{lanes[1]}}, {8{lanes[0]}}};
   endfunction

   // Bus cycle engine shared by the command, data, verify command and read phases
   dbfw_bus_cycle u_cycle (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .start(bc_start),
      .is_write(bc_write),
      .lanes(bc_lanes),
      .addr(addr_reg),
      .wdata(bc_wdata),
      .done(bc_done),
      .rdata(bc_rdata),
      .flash_addr(flash_addr),
      .low_byte_select_n(low_byte_select_n),
      .high_byte_select_n(high_byte_select_n),
      .write_strobe_n(write_strobe_n),
      .output_enable_n(output_enable_n),
      .flash_dq_out(flash_dq_out),
      .flash_dq_oe_n(flash_dq_oe_n),
      .flash_dq_in(flash_dq_in)
   );

   assign req_ready = (state_reg == HS_IDLE);
   assign bc_start = !issued_reg && (state_reg == HS_CMD || state_reg == HS_DATA
      || state_reg == HS_VERIFY_CMD || state_reg == HS_READ);
   assign bc_write = (state_reg != HS_READ);
   // Both lanes selected on writes so the idle lane takes the null command
   assign bc_lanes = (state_reg == HS_READ) ? lanes_reg : LANE_BOTH;

   always_comb begin
      bc_wdata = 16'h0000;
      unique case (state_reg)
         HS_CMD: bc_wdata = lane_cmd(op_reg == OP_ERASE ? CMD_ERASE_SETUP : CMD_PROGRAM, lanes_reg);
         // Idle lane of a single-lane program gets 00H, never stray data bytes
         HS_DATA: bc_wdata = (op_reg == OP_ERASE) ? lane_cmd(CMD_ERASE, lanes_reg)
            : (wdata_reg & lane_mask(lanes_reg));
         HS_VERIFY_CMD: bc_wdata = lane_cmd(op_reg == OP_ERASE ? CMD_ERASE_VERIFY : CMD_PROG_VERIFY, lanes_reg);
         default: bc_wdata = 16'h0000;
      endcase
   end

   // One start per phase; cleared when the bus cycle reports done
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         issued_reg <= 1'b0;
      end else if (bc_done) begin
         issued_reg <= 1'b0;
      end else if (bc_start) begin
         issued_reg <= 1'b1;
      end
   end

   // Request fields stay put for the whole operation
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         op_reg <= OP_READ;
         lanes_reg <= LANE_BOTH;
         addr_reg <= 17'h00000;
         wdata_reg <= 16'h0000;
      end else if (req_valid && req_ready) begin
         op_reg <= req_op;
         lanes_reg <= (req_lanes == 2'h0) ? LANE_BOTH : req_lanes;
         addr_reg <= req_addr;
         wdata_reg <= req_wdata;
      end
   end

   // Shared delay counter, loaded on entry to each waiting state
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wait_reg <= '0;
      end else if (state_reg == HS_DATA && bc_done) begin
         // Program waits at least its duration, erase sits mid-window
         wait_reg <= (op_reg == OP_ERASE) ? CNT_W'(ERASE_CYCLES) : CNT_W'(PROG_CYCLES);
      end else if (state_reg == HS_VERIFY_CMD && bc_done) begin
         wait_reg <= CNT_W'(RECOV_CYCLES);
      end else if (wait_reg != '0) begin
         wait_reg <= wait_reg - CNT_W'(1);
      end
   end

   // Phase order: command, data, wait, verify command, recovery, read
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= HS_IDLE;
      end else begin
         unique case (state_reg)
            HS_IDLE: begin
               if (req_valid) begin
                  state_reg <= (req_op == OP_READ) ? HS_READ : HS_CMD;
               end
            end
            HS_CMD: begin
               if (bc_done) begin
                  state_reg <= HS_DATA;
               end
            end
            HS_DATA: begin
               if (bc_done) begin
                  state_reg <= HS_WAIT;
               end
            end
            HS_WAIT: begin
               // No command reaches the device before the wait runs out
               if (wait_reg == '0) begin
                  state_reg <= HS_VERIFY_CMD;
               end
            end
            HS_VERIFY_CMD: begin
               if (bc_done) begin
                  state_reg <= HS_RECOVER;
               end
            end
            HS_RECOVER: begin
               if (wait_reg == '0) begin
                  state_reg <= HS_READ;
               end
            end
            HS_READ: begin
               if (bc_done) begin
                  state_reg <= HS_DONE;
               end
            end
            HS_DONE: begin
               state_reg <= HS_IDLE;
            end
         endcase
      end
   end

   // One-cycle answer strobe as the sequence closes
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         resp_valid <= 1'b0;
      end else begin
         resp_valid <= (state_reg == HS_DONE);
      end
   end

   // Program verify compares only the lanes under test; erase verify never sets the mismatch flag
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         resp_rdata <= 16'h0000;
         resp_mismatch <= 1'b0;
      end else if (state_reg == HS_READ && bc_done) begin
         resp_rdata <= bc_rdata;
         resp_mismatch <= (op_reg == OP_PROGRAM) &&
            ((bc_rdata & lane_mask(lanes_reg)) != (wdata_reg & lane_mask(lanes_reg)));
      end
   end
endmodule
`default_nettype wire

// File: core/dbfw_pkg.sv
// Constants for the dual byte flash command-write host controller
// Summary of operation
// - Word commands repeat the byte on both lanes
// - Program setup 4040H, then the 16-bit data write
// - Single-lane operation writes 00H to the other lane
// - Host releases the bus during verify reads
// - Write occurs only while select and strobe active
// - Program runs at least 10 us before next command
// - Erase runs between 9.5 and 10.5 ms
// - Wait 6 us write recovery before reads
package dbfw_pkg;
   localparam int CLK_MHZ = 200;
   localparam logic [7:0] CMD_PROGRAM = 8'h40;
   localparam logic [7:0] CMD_NULL = 8'h00;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
   localparam logic [7:0] CMD_ERASE = 8'h20;
   localparam logic [7:0] CMD_PROG_VERIFY = 8'hC0;
   localparam logic [7:0] CMD_ERASE_VERIFY = 8'hA0;
   localparam logic [7:0] CMD_READ = 8'h00;
   // Times in ns; the erase window is centred in 9.5 to 10.5 ms
   localparam int PROGRAM_DURATION_NS = 10000;
   localparam int ERASE_DURATION_NS = 10000000;
   localparam int WRITE_RECOVERY_NS = 6000;
   localparam int WRITE_PULSE_NS = 80;
   localparam int SETUP_NS = 50;
   localparam int HOLD_NS = 60;
   localparam int ACCESS_NS = 250;
   localparam int CLK_NS = 1000 / CLK_MHZ;
   localparam int PROG_CYC = (PROGRAM_DURATION_NS + CLK_NS - 1) / CLK_NS;
   localparam int ERASE_CYC = ERASE_DURATION_NS / CLK_NS;
   localparam int RECOV_CYC = (WRITE_RECOVERY_NS + CLK_NS - 1) / CLK_NS;
   localparam int PULSE_CYC = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS + 2;
   localparam int CNT_W = 24;
   // Operation and lane codes on the user port
   localparam logic [1:0] OP_PROGRAM = 2'h0;
   localparam logic [1:0] OP_ERASE = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] LANE_BOTH = 2'h3;
   localparam logic [1:0] LANE_LOW = 2'h1;
   localparam logic [1:0] LANE_HIGH = 2'h2;
endpackage

// File: tb/dbfw_flash_model.sv
// Behavioural two-lane flash device facing the host controller
`timescale 1ns/1ps
`default_nettype none
module dbfw_flash_model
   import dbfw_pkg::*;
#(
   parameter int ACC_NS = 200
)
(
   // Clock for the released-line pattern
   input wire logic clk_sys,
   // Device pins
   input wire logic [16:0] flash_addr,
   input wire logic low_byte_select_n,
   input wire logic high_byte_select_n,
   input wire logic write_strobe_n,
   input wire logic output_enable_n,
   input wire logic [15:0] flash_dq_out,
   input wire logic flash_dq_oe_n,
   // Resolved data lanes
   output logic [15:0] flash_dq_in
);
   logic [7:0] mem [2][131072];
   logic [1:0] mode [2];
   logic [15:0] last_reg, dev_dq;
   logic [1:0] sel;
   assign sel = {!high_byte_select_n, !low_byte_select_n};
   // Slow device: old contents show until the access time has run
   assign #(ACC_NS) dev_dq = {mem[1][flash_addr], mem[0][flash_addr]};
   initial begin
      foreach (mem[l, a]) mem[l][a] = 8'hFF;
      mode[0] = 2'h0;
      mode[1] = 2'h0;
   end
   always @(posedge write_strobe_n) begin
      for (int l = 0; l < 2; l++) begin
         if (sel[l]) begin
            if (mode[l] == 2'h1) begin
               // Programming only clears bits
               mem[l][flash_addr] = mem[l][flash_addr] & flash_dq_out[l*8 +: 8];
               mode[l] = 2'h0;
            end else if (mode[l] == 2'h2 && flash_dq_out[l*8 +: 8] == CMD_ERASE) begin
               for (int a = 0; a < 131072; a++)
                  mem[l][a] = 8'hFF;
               mode[l] = 2'h0;
            end else begin
               case (flash_dq_out[l*8 +: 8])
                  CMD_PROGRAM: mode[l] = 2'h1;
                  CMD_ERASE_SETUP: mode[l] = 2'h2;
                  CMD_PROG_VERIFY, CMD_ERASE_VERIFY: mode[l] = 2'h3;
                  default: mode[l] = 2'h0;
               endcase
            end
         end
      end
   end
   // Undriven lanes show a pattern that flips every cycle
   always @* begin
      for (int l = 0; l < 2; l++) begin
         if (sel[l] && !output_enable_n)
            flash_dq_in[l*8 +: 8] = dev_dq[l*8 +: 8];
         else if (!flash_dq_oe_n)
            flash_dq_in[l*8 +: 8] = flash_dq_out[l*8 +: 8];
         else
            flash_dq_in[l*8 +: 8] = ~last_reg[l*8 +: 8];
      end
   end
   always @(posedge clk_sys) last_reg <= flash_dq_in;
endmodule
`default_nettype wire

// File: tb/dbfw_props.sv
// Concurrent checks on the flash pins of the host controller
`timescale 1ns/1ps
`default_nettype none
module dbfw_props
   import dbfw_pkg::*;
#(
   parameter int PROG_CYCLES = 20,
   parameter int ERASE_CYCLES = 40,
   parameter int RECOV_CYCLES = 12
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Flash pins
   input wire logic [16:0] flash_addr,
   input wire logic low_byte_select_n,
   input wire logic high_byte_select_n,
   input wire logic write_strobe_n,
   input wire logic output_enable_n,
   input wire logic [15:0] flash_dq_out,
   input wire logic flash_dq_oe_n
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   int unsigned gap_reg;
   logic [15:0] last_reg, prev_reg;
   function automatic logic is_cmd(logic [15:0] w, logic [7:0] c);
      return w == {c, c} || w == {c, CMD_NULL} || w == {CMD_NULL, c};
   endfunction
   // Cycles since a write ended; saturates so long idle never wraps
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         gap_reg <= 32'h000F_FFFF;
      else if ($rose(write_strobe_n))
         gap_reg <= 32'h0000_0000;
      else if (gap_reg < 32'h000F_FFFF)
         gap_reg <= gap_reg + 32'h0000_0001;
   end
   // Last two written words, captured as each strobe starts
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         last_reg <= 16'h0000;
         prev_reg <= 16'h0000;
      end else if ($fell(write_strobe_n)) begin
         last_reg <= flash_dq_out;
         prev_reg <= last_reg;
      end
   end
   property p_write_gated;
      !write_strobe_n |-> output_enable_n && !flash_dq_oe_n && !(low_byte_select_n && high_byte_select_n);
   endproperty
   a_write_gated: assert property (p_write_gated) else $error("strobe without select or drive");
   property p_select_leads;
      $fell(write_strobe_n) |-> !$past(low_byte_select_n) || !$past(high_byte_select_n);
   endproperty
   a_select_leads: assert property (p_select_leads) else $error("select not ahead of strobe");
   property p_pins_steady;
      !write_strobe_n && !$past(write_strobe_n) |-> $stable(flash_addr) && $stable(flash_dq_out)
         && $stable(low_byte_select_n) && $stable(high_byte_select_n);
   endproperty
   a_pins_steady: assert property (p_pins_steady) else $error("pins moved during strobe");
   property p_read_released;
      !output_enable_n |-> flash_dq_oe_n && write_strobe_n;
   endproperty
   a_read_released: assert property (p_read_released) else $error("host drives during read");
   property p_cmd_repeat;
      $fell(write_strobe_n) && !is_cmd(last_reg, CMD_PROGRAM) |-> flash_dq_out[15:8] == flash_dq_out[7:0]
         || flash_dq_out[15:8] == CMD_NULL || flash_dq_out[7:0] == CMD_NULL;
   endproperty
   a_cmd_repeat: assert property (p_cmd_repeat) else $error("command bytes differ");
   property p_program_time;
      $fell(write_strobe_n) && is_cmd(prev_reg, CMD_PROGRAM) |-> gap_reg >= PROG_CYCLES;
   endproperty
   a_program_time: assert property (p_program_time) else $error("program cut short");
   // Upper bound allows pin overhead at small test counts
   property p_erase_time;
      $fell(write_strobe_n) && is_cmd(prev_reg, CMD_ERASE_SETUP) && is_cmd(last_reg, CMD_ERASE)
         |-> gap_reg >= ERASE_CYCLES * 19 / 20 && gap_reg <= ERASE_CYCLES * 21 / 20 + 64;
   endproperty
   a_erase_time: assert property (p_erase_time) else $error("erase time out of window");
   property p_recovery;
      $fell(output_enable_n) |-> gap_reg >= RECOV_CYCLES;
   endproperty
   a_recovery: assert property (p_recovery) else $error("read too soon after write");
endmodule
bind dbfw_host dbfw_props #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES), .RECOV_CYCLES(RECOV_CYCLES))
   i_props (.clk_sys(clk_sys), .reset_n(reset_n), .flash_addr(flash_addr), .low_byte_select_n(low_byte_select_n),
   .high_byte_select_n(high_byte_select_n), .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
   .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n));
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the dual byte flash host controller
`timescale 1ns/1ps
`default_nettype none
module tb;
   import dbfw_pkg::*;
   logic clk_sys, reset_n, req_valid, req_ready, resp_valid, resp_mismatch, mm;
   logic [1:0] req_op, req_lanes;
   logic [16:0] req_addr, flash_addr;
   logic [15:0] req_wdata, resp_rdata, flash_dq_out, flash_dq_in, rd;
   logic low_byte_select_n, high_byte_select_n, write_strobe_n, output_enable_n, flash_dq_oe_n;
   int n_errors, comparisons;
   dbfw_host #(.PROG_CYCLES(20), .ERASE_CYCLES(40), .RECOV_CYCLES(12)) i_dut (.clk_sys(clk_sys),
      .reset_n(reset_n), .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_lanes(req_lanes),
      .req_addr(req_addr), .req_wdata(req_wdata), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
      .resp_mismatch(resp_mismatch), .flash_addr(flash_addr), .low_byte_select_n(low_byte_select_n),
      .high_byte_select_n(high_byte_select_n), .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
      .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n), .flash_dq_in(flash_dq_in));
   dbfw_flash_model #(.ACC_NS(200)) i_flash (.clk_sys(clk_sys), .flash_addr(flash_addr),
      .low_byte_select_n(low_byte_select_n), .high_byte_select_n(high_byte_select_n),
      .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n), .flash_dq_out(flash_dq_out),
      .flash_dq_oe_n(flash_dq_oe_n), .flash_dq_in(flash_dq_in));
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic tmo(int n, int lim);
      if (n >= lim) begin
         chk("wait bound", 16'h0001, 16'h0000);
         results();
      end
   endtask
   // One request through the user port; answer lands in rd and mm
   task automatic run_op(logic [1:0] op, logic [1:0] lanes, logic [16:0] addr, logic [15:0] wdata);
      int n;
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_op <= op;
      req_lanes <= lanes;
      req_addr <= addr;
      req_wdata <= wdata;
      @(negedge clk_sys);
      for (n = 0; req_ready !== 1'b1 && n < 100; n++)
         @(negedge clk_sys);
      tmo(n, 100);
      @(posedge clk_sys);
      req_valid <= 1'b0;
      for (n = 0; resp_valid !== 1'b1 && n < 2000; n++)
         @(negedge clk_sys);
      tmo(n, 2000);
      rd = resp_rdata;
      mm = resp_mismatch;
   endtask
   task automatic t_program_word();
      run_op(OP_PROGRAM, LANE_BOTH, 17'h00001, 16'hA55A);
      chk("word verify data", rd, 16'hA55A);
      chk("word verify flag", mm, 16'h0000);
      run_op(OP_READ, LANE_BOTH, 17'h00001, 16'h0000);
      chk("word read", rd, 16'hA55A);
      $display("program word done");
   endtask
   task automatic t_program_lane();
      run_op(OP_PROGRAM, LANE_LOW, 17'h00002, 16'h123C);
      chk("low lane verify", rd & 16'h00FF, 16'h003C);
      chk("low lane flag", mm, 16'h0000);
      run_op(OP_PROGRAM, LANE_HIGH, 17'h00002, 16'hC340);
      chk("high lane verify", rd & 16'hFF00, 16'hC300);
      run_op(OP_READ, 2'h0, 17'h00002, 16'h0000);
      chk("lanes read", rd, 16'hC33C);
      $display("program lane done");
   endtask
   task automatic t_mismatch();
      run_op(OP_PROGRAM, LANE_BOTH, 17'h00001, 16'h5AA5);
      chk("cleared verify data", rd, 16'h0000);
      chk("cleared verify flag", mm, 16'h0001);
      $display("mismatch done");
   endtask
   task automatic t_erase();
      run_op(OP_ERASE, LANE_LOW, 17'h00000, 16'h0000);
      chk("low erase verify", rd & 16'h00FF, 16'h00FF);
      chk("erase flag", mm, 16'h0000);
      run_op(OP_READ, LANE_BOTH, 17'h00002, 16'h0000);
      chk("high lane kept", rd, 16'hC3FF);
      run_op(OP_ERASE, LANE_BOTH, 17'h00000, 16'h0000);
      run_op(OP_READ, LANE_BOTH, 17'h00002, 16'h0000);
      chk("word erased", rd, 16'hFFFF);
      $display("erase done");
   endtask
   initial begin
      n_errors = 0;
      comparisons = 0;
      reset_n = 1'b0;
      req_valid = 1'b0;
      req_op = 2'h0;
      req_lanes = 2'h0;
      req_addr = 17'h00000;
      req_wdata = 16'h0000;
      repeat (16) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(negedge clk_sys);
      chk("idle pins", {10'h000, low_byte_select_n, high_byte_select_n, write_strobe_n, output_enable_n,
         flash_dq_oe_n, req_ready}, 16'h003F);
      t_program_word();
      t_program_lane();
      t_mismatch();
      t_erase();
      results();
   end
endmodule
`default_nettype wire
